// File: design/dsp_channel.sv
// One compare channel: match detection and output waveform register
`timescale 1ns/10ps
module dsp_channel #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Counter state
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic [W-1:0] count,
  input  wire logic [W-1:0] top,
  input  wire logic         dir_down,
  // Channel setup
  input  wire logic [W-1:0] value,
  input  wire logic [1:0]   action,
  input  wire logic         toggle_ok,
  // Results
  output logic              match,
  output logic              compare_output
);

  logic eff_down;

  // Match only counts on a tick of a running counter
  // match detection
  assign match = tick && run && (count == value);

  // Top is judged downward and bottom upward, so extreme values give flat levels
  // extreme values
  assign eff_down = (count == top) ? 1'b1 : (count == dsp_pkg::BOTTOM) ? 1'b0 : dir_down;

  // Waveform register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_output <= 1'b0;
    end else if (match) begin
      case (action)
        dsp_pkg::ACT_NONINV: compare_output <= eff_down;
        dsp_pkg::ACT_INV:    compare_output <= !eff_down;
        dsp_pkg::ACT_TOGGLE: compare_output <= toggle_ok ? !compare_output : compare_output;
        default:             compare_output <= compare_output;
      endcase
    end
  end

endmodule // dsp_channel

// File: design/dsp_pkg.sv
// Package holding register map, field layout and mode codes of the dual-slope PWM timer
package dsp_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_CTRL_A  = 8'h80;
  localparam logic [7:0] OFF_CTRL_B  = 8'h84;
  localparam logic [7:0] OFF_CMP_A   = 8'h88;
  localparam logic [7:0] OFF_CMP_B   = 8'h8C;
  localparam logic [7:0] OFF_CAPT    = 8'h90;
  localparam logic [7:0] OFF_COUNT   = 8'h94;
  localparam logic [7:0] OFF_FLAGS   = 8'h98;
  localparam logic [7:0] OFF_PIN_DIR = 8'h9C;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ACT_A_LSB     = 6;
  localparam int ACT_B_LSB     = 4;
  localparam int WSEL_LOW_LSB  = 0;
  localparam int WSEL_HIGH_LSB = 0;
  localparam int CLKSEL_LSB    = 2;
  localparam int FLAG_OVF      = 0;
  localparam int FLAG_CMP_A    = 1;
  localparam int FLAG_CMP_B    = 2;
  localparam int FLAG_CAPT     = 3;
  localparam int DIR_A         = 0;
  localparam int DIR_B         = 1;

  // ************************************************************
  // Reset values and write masks
  // ************************************************************
  localparam logic [7:0]  CTRL_A_RST   = 8'h00;
  localparam logic [7:0]  CTRL_A_WMASK = 8'hF3;
  localparam logic [7:0]  CTRL_B_RST   = 8'h00;
  localparam logic [7:0]  CTRL_B_WMASK = 8'h1F;
  localparam logic [15:0] VALUE_RST    = 16'h0000;
  localparam logic [15:0] BOTTOM       = 16'h0000;
  localparam logic [1:0]  DIR_RST      = 2'h0;

  // ************************************************************
  // Mode, action and prescaler codes
  // ************************************************************
  localparam logic [3:0] WSEL_TOP_CAPT  = 4'h8;
  localparam logic [3:0] WSEL_TOP_CMP_A = 4'h9;
  localparam logic [3:0] WSEL_PC_CMP_A  = 4'hB;
  localparam logic [1:0] ACT_OFF        = 2'h0;
  localparam logic [1:0] ACT_TOGGLE     = 2'h1;
  localparam logic [1:0] ACT_NONINV     = 2'h2;
  localparam logic [1:0] ACT_INV        = 2'h3;
  localparam logic [2:0] CLKSEL_DIV1    = 3'h1;
  localparam logic [2:0] CLKSEL_DIV8    = 3'h2;
  localparam logic [2:0] CLKSEL_DIV64   = 3'h3;
  localparam logic [2:0] CLKSEL_DIV256  = 3'h4;
  localparam logic [2:0] CLKSEL_DIV1024 = 3'h5;
  localparam logic [9:0] DIV1_LAST      = 10'h000;
  localparam logic [9:0] DIV8_LAST      = 10'h007;
  localparam logic [9:0] DIV64_LAST     = 10'h03F;
  localparam logic [9:0] DIV256_LAST    = 10'h0FF;
  localparam logic [9:0] DIV1024_LAST   = 10'h3FF;

  // ************************************************************
  // Bus answers and count direction
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {dsp_count_up, dsp_count_down} dsp_dir_e;

endpackage

// File: design/dsp_timer.sv
// Dual-slope phase and frequency correct PWM timer with AXI4-Lite registers
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
module dsp_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Compare output pins
  output logic              compare_output_a,
  output logic              compare_output_a_oe,
  output logic              compare_output_b,
  output logic              compare_output_b_oe
);

  // ************************************************************
  // Registers and state
  // ************************************************************
  logic [7:0]        ctrl_a;
  logic [7:0]        ctrl_b;
  logic [W-1:0]      cmp_a_buf;
  logic [W-1:0]      cmp_b_buf;
  logic [W-1:0]      cmp_a_act;
  logic [W-1:0]      cmp_b_act;
  logic [W-1:0]      capture_value;
  logic [W-1:0]      count_value;
  logic [3:0]        flags;
  logic [1:0]        pin_direction_bit;
  dsp_pkg::dsp_dir_e dir;
  logic [9:0]        presc_cnt;
  logic [9:0]        presc_last;
  logic              timer_tick;
  logic [7:0]        aw_addr;
  logic              aw_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_held;
  logic              do_write;
  logic              wr_hit;
  logic [31:0]       rd_word;
  logic              rd_hit;

  logic [1:0]        output_action_a;
  logic [1:0]        output_action_b;
  logic [3:0]        waveform_select;
  logic [2:0]        clk_select;
  logic              run;
  logic              toggle_ok;
  logic [W-1:0]      top;
  logic              at_top;
  logic              at_bottom;
  logic              match_a;
  logic              match_b;
  logic              pin_a;
  logic              pin_b;
  logic [3:0]        flag_set;
  logic [3:0]        flag_clr;

  assign output_action_a = ctrl_a[dsp_pkg::ACT_A_LSB +: 2];
  assign output_action_b = ctrl_a[dsp_pkg::ACT_B_LSB +: 2];
  assign waveform_select = {ctrl_b[dsp_pkg::WSEL_HIGH_LSB +: 2],
                            ctrl_a[dsp_pkg::WSEL_LOW_LSB +: 2]};
  assign clk_select      = ctrl_b[dsp_pkg::CLKSEL_LSB +: 3];

  // ************************************************************
  // Prescaler
  // ************************************************************
  // Divider end value per clock select; unknown codes stop the timer
  always_comb begin
    if (clk_select == dsp_pkg::CLKSEL_DIV1) begin
      presc_last = dsp_pkg::DIV1_LAST;
    end else if (clk_select == dsp_pkg::CLKSEL_DIV8) begin
      presc_last = dsp_pkg::DIV8_LAST;
    end else if (clk_select == dsp_pkg::CLKSEL_DIV64) begin
      presc_last = dsp_pkg::DIV64_LAST;
    end else if (clk_select == dsp_pkg::CLKSEL_DIV256) begin
      presc_last = dsp_pkg::DIV256_LAST;
    end else begin
      presc_last = dsp_pkg::DIV1024_LAST;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_cnt  <= 10'h000;
      timer_tick <= 1'b0;
    end else if (clk_select < dsp_pkg::CLKSEL_DIV1 || clk_select > dsp_pkg::CLKSEL_DIV1024) begin
      presc_cnt  <= 10'h000;
      timer_tick <= 1'b0;
    end else if (presc_cnt >= presc_last) begin
      presc_cnt  <= 10'h000;
      timer_tick <= 1'b1;
    end else begin
      presc_cnt  <= presc_cnt + 10'h001;
      timer_tick <= 1'b0;
    end
  end

  // ************************************************************
  // Counter
  // ************************************************************
  // top source select
  assign run       = (waveform_select == dsp_pkg::WSEL_TOP_CAPT) ||
                     (waveform_select == dsp_pkg::WSEL_TOP_CMP_A);
  assign top       = (waveform_select == dsp_pkg::WSEL_TOP_CAPT) ? capture_value : cmp_a_act;
  assign at_top    = (count_value == top);
  assign at_bottom = (count_value == dsp_pkg::BOTTOM);

  // Other counting modes are outside this block, so the counter parks at bottom
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value <= dsp_pkg::BOTTOM;
      dir         <= dsp_pkg::dsp_count_up;
    end else if (!run) begin
      count_value <= dsp_pkg::BOTTOM;
      dir         <= dsp_pkg::dsp_count_up;
    end else if (timer_tick) begin
      // dual slope; top is ignored at bottom, where it may still be stale
      if (dir == dsp_pkg::dsp_count_up && at_top && !at_bottom) begin
        dir         <= dsp_pkg::dsp_count_down;
        count_value <= count_value - 16'h0001;
      end else if (dir == dsp_pkg::dsp_count_down && at_bottom) begin
        dir         <= dsp_pkg::dsp_count_up;
        count_value <= count_value + 16'h0001;
      end else if (dir == dsp_pkg::dsp_count_up) begin
        count_value <= count_value + 16'h0001;
      end else begin
        count_value <= count_value - 16'h0001;
      end
    end
  end

  // Buffered compare values move to the active copies at bottom only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_a_act <= dsp_pkg::VALUE_RST;
      cmp_b_act <= dsp_pkg::VALUE_RST;
    end else if (run && timer_tick && at_bottom) begin
      cmp_a_act <= cmp_a_buf;
      cmp_b_act <= cmp_b_buf;
    end
  end

  // ************************************************************
  // Compare channels and pins
  // ************************************************************
  // toggle only in modes 9 and 11
  assign toggle_ok = (waveform_select == dsp_pkg::WSEL_TOP_CMP_A) ||
                     (waveform_select == dsp_pkg::WSEL_PC_CMP_A);

  dsp_channel #(.W(W)) u_chan_a (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .tick           (timer_tick),
    .run            (run),
    .count          (count_value),
    .top            (top),
    .dir_down       (dir == dsp_pkg::dsp_count_down),
    .value          (cmp_a_act),
    .action         (output_action_a),
    .toggle_ok      (toggle_ok),
    .match          (match_a),
    .compare_output (pin_a)
  );

  dsp_channel #(.W(W)) u_chan_b (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .tick           (timer_tick),
    .run            (run),
    .count          (count_value),
    .top            (top),
    .dir_down       (dir == dsp_pkg::dsp_count_down),
    .value          (cmp_b_act),
    .action         (output_action_b),
    .toggle_ok      (1'b0),
    .match          (match_b),
    .compare_output (pin_b)
  );

  // Pins follow the waveform registers; enables need a connected action and direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_output_a    <= 1'b0;
      compare_output_b    <= 1'b0;
      compare_output_a_oe <= 1'b0;
      compare_output_b_oe <= 1'b0;
    end else begin
      compare_output_a    <= pin_a;
      compare_output_b    <= pin_b;
      compare_output_a_oe <= pin_direction_bit[dsp_pkg::DIR_A] &&
                             (output_action_a[1] ||
                              (output_action_a == dsp_pkg::ACT_TOGGLE && toggle_ok));
      compare_output_b_oe <= pin_direction_bit[dsp_pkg::DIR_B] && output_action_b[1];
    end
  end

  // ************************************************************
  // Flags
  // ************************************************************
  always_comb begin
    flag_set = 4'h0;
    flag_set[dsp_pkg::FLAG_OVF]   = run && timer_tick && at_bottom;
    flag_set[dsp_pkg::FLAG_CMP_A] = match_a;
    flag_set[dsp_pkg::FLAG_CMP_B] = match_b;
    flag_set[dsp_pkg::FLAG_CAPT]  = run && timer_tick && at_top &&
                                    (waveform_select == dsp_pkg::WSEL_TOP_CAPT);
    flag_clr = (do_write && aw_addr == dsp_pkg::OFF_FLAGS && w_strb[0]) ? w_data[3:0] : 4'h0;
  end

  // Write-one-to-clear; a new event in the clear cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= 4'h0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // ************************************************************
  // AXI4-Lite write path
  // ************************************************************
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit   = (aw_addr == dsp_pkg::OFF_CTRL_A) || (aw_addr == dsp_pkg::OFF_CTRL_B) ||
                    (aw_addr == dsp_pkg::OFF_CMP_A)  || (aw_addr == dsp_pkg::OFF_CMP_B)  ||
                    (aw_addr == dsp_pkg::OFF_CAPT)   || (aw_addr == dsp_pkg::OFF_COUNT)  ||
                    (aw_addr == dsp_pkg::OFF_FLAGS)  || (aw_addr == dsp_pkg::OFF_PIN_DIR);

  // Address and data are caught independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= dsp_pkg::RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? dsp_pkg::RESP_OKAY : dsp_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register stores; byte strobes select the lanes written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a            <= dsp_pkg::CTRL_A_RST;
      ctrl_b            <= dsp_pkg::CTRL_B_RST;
      cmp_a_buf         <= dsp_pkg::VALUE_RST;
      cmp_b_buf         <= dsp_pkg::VALUE_RST;
      capture_value     <= dsp_pkg::VALUE_RST;
      pin_direction_bit <= dsp_pkg::DIR_RST;
    end else if (do_write) begin
      if (aw_addr == dsp_pkg::OFF_CTRL_A) begin
        if (w_strb[0]) ctrl_a <= w_data[7:0] & dsp_pkg::CTRL_A_WMASK;
      end else if (aw_addr == dsp_pkg::OFF_CTRL_B) begin
        if (w_strb[0]) ctrl_b <= w_data[7:0] & dsp_pkg::CTRL_B_WMASK;
      end else if (aw_addr == dsp_pkg::OFF_CMP_A) begin
        if (w_strb[0]) cmp_a_buf[7:0]  <= w_data[7:0];
        if (w_strb[1]) cmp_a_buf[15:8] <= w_data[15:8];
      end else if (aw_addr == dsp_pkg::OFF_CMP_B) begin
        if (w_strb[0]) cmp_b_buf[7:0]  <= w_data[7:0];
        if (w_strb[1]) cmp_b_buf[15:8] <= w_data[15:8];
      end else if (aw_addr == dsp_pkg::OFF_CAPT) begin
        // Not buffered: a change bites at once, so a running top may skew one period
        if (w_strb[0]) capture_value[7:0]  <= w_data[7:0];
        if (w_strb[1]) capture_value[15:8] <= w_data[15:8];
      end else if (aw_addr == dsp_pkg::OFF_PIN_DIR) begin
        if (w_strb[0]) pin_direction_bit <= w_data[1:0];
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read path
  // ************************************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr[7:2] == dsp_pkg::OFF_CTRL_A[7:2]) begin
      rd_word[7:0] = ctrl_a;
    end else if (s_axi_araddr[7:2] == dsp_pkg::OFF_CTRL_B[7:2]) begin
      rd_word[7:0] = ctrl_b;
    end else if (s_axi_araddr[7:2] == dsp_pkg::OFF_CMP_A[7:2]) begin
      rd_word[15:0] = cmp_a_buf;
    end else if (s_axi_araddr[7:2] == dsp_pkg::OFF_CMP_B[7:2]) begin
      rd_word[15:0] = cmp_b_buf;
    end else if (s_axi_araddr[7:2] == dsp_pkg::OFF_CAPT[7:2]) begin
      rd_word[15:0] = capture_value;
    end else if (s_axi_araddr[7:2] == dsp_pkg::OFF_COUNT[7:2]) begin
      rd_word[15:0] = count_value;
    end else if (s_axi_araddr[7:2] == dsp_pkg::OFF_FLAGS[7:2]) begin
      rd_word[3:0] = flags;
    end else if (s_axi_araddr[7:2] == dsp_pkg::OFF_PIN_DIR[7:2]) begin
      rd_word[1:0] = pin_direction_bit;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One read at a time; answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= dsp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? dsp_pkg::RESP_OKAY : dsp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule // dsp_timer

// File: verification/dsp_pin_load.sv
// External load on one compare output pin
`timescale 1ns/10ps
module dsp_pin_load (
  // Pin as driven by the timer
  input  wire logic drive,
  input  wire logic oe,
  // Level seen by the load
  output logic      level
);
  // pull-down while undriven
  // An undriven pin reads low, never the last driven level
  assign level = oe ? drive : 1'b0;
endmodule // dsp_pin_load

// File: verification/dsp_timer_sva.sv
// Bus and pin checker for the dual-slope PWM timer
`timescale 1ns/10ps
module dsp_timer_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus signals watched
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pin enable
  input wire logic        compare_output_a_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] rd_addr;
  // Address of the read under way, for judging its answer
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_addr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  AST_RD_NEXT: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  AST_RD_HOLD: assert property (s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed while waiting");
  AST_AR_QUIET: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted during answer");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped while waiting");
  AST_AW_QUIET: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted during answer");
  AST_CTRL_RSVD: assert property (s_axi_rvalid && rd_addr == 8'h80 |->
    (s_axi_rdata & 32'hFFFFFF0C) == 32'h00000000) else $error("control reserved bits set");
  AST_UNMAP: assert property (s_axi_rvalid && rd_addr[7:5] != 3'h4 |->
    s_axi_rresp == dsp_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  AST_MAP_OK: assert property (s_axi_rvalid && rd_addr[7:5] == 3'h4 |->
    s_axi_rresp == dsp_pkg::RESP_OKAY) else $error("mapped read refused");
  AST_OE_WRITE: assert property (!$stable(compare_output_a_oe) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("pin enable moved without a write");
endmodule // dsp_timer_chk
bind dsp_timer dsp_timer_chk i_dsp_timer_chk (.*);

// File: verification/tb_top.sv
// Self-checking bench for the dual-slope PWM timer
`timescale 1ns/10ps
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        compare_output_a, compare_output_a_oe, compare_output_b, compare_output_b_oe;
  logic        lvl_a, lvl_b;
  int          bad_count = 0, compares = 0;
  dsp_timer i_dsp_timer (.*);
  dsp_pin_load i_dsp_pin_load (.drive(compare_output_a), .oe(compare_output_a_oe), .level(lvl_a));
  dsp_pin_load i_dsp_pin_load_b (.drive(compare_output_b), .oe(compare_output_b_oe), .level(lvl_b));
  // 200 MHz clock
  always #2.5 aclk = ~aclk;
  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Reset restarts the timer, so each scenario begins from bottom
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // Address and data offered together, each released once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    check("write answer", {30'h0, s_axi_bresp}, 32'h0);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic t_regs();
    do_reset();
    axi_read(8'h80);
    check("control reset", rd, 32'h0);
    axi_read(8'h94);
    check("count reset", rd, 32'h0);
    axi_write(8'h80, 32'hFFFFFFFF);
    axi_read(8'h80);
    check("control fields", rd, 32'hF3);
    axi_read(8'h40);
    check("unmapped answer", {30'h0, rr}, {30'h0, dsp_pkg::RESP_SLVERR});
    $display("test regs done");
  endtask
  // Whole periods are counted, so the phase at start does not matter
  task automatic run_pwm(input string nm, input logic [7:0] cb, ca, dir,
                         input logic [15:0] c1, c2, tp, input int settle, n, ea, eb);
    int ha, hb;
    ha = 0;
    hb = 0;
    do_reset();
    // callers keep top at least three and at or above every compare
    axi_write(8'h88, {16'h0, c1});
    axi_write(8'h8C, {16'h0, c2});
    axi_write(8'h90, {16'h0, tp});
    axi_write(8'h9C, {24'h0, dir});
    axi_write(8'h80, {24'h0, ca});
    axi_write(8'h84, {24'h0, cb});
    repeat (settle) @(posedge aclk);
    repeat (n) begin
      @(negedge aclk);
      if (lvl_a === 1'b1) ha++;
      if (lvl_b === 1'b1) hb++;
    end
    check({nm, " high a"}, ha, ea);
    check({nm, " high b"}, hb, eb);
    $display("test %s done", nm);
  endtask
  task automatic t_pwm();
    run_pwm("pwm", 8'h06, 8'hB0, 8'h03, 16'h3, 16'h3, 16'h8, 40, 32, 12, 20);
    axi_read(8'h98);
    check("flags", rd, 32'hF);
    axi_write(8'h84, 32'h2);
    axi_write(8'h98, 32'hF);
    axi_read(8'h98);
    check("flags cleared", rd, 32'h0);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    test_done();
  end
  initial begin
    t_regs();
    t_pwm();
    run_pwm("edge", 8'h06, 8'hA0, 8'h03, 16'h0, 16'h8, 16'h8, 40, 32, 0, 32);
    run_pwm("toggle", 8'h06, 8'h41, 8'h03, 16'h5, 16'h0, 16'h0, 40, 40, 20, 0);
    run_pwm("slow", 8'h0A, 8'hB0, 8'h03, 16'h3, 16'h3, 16'h8, 300, 256, 96, 160);
    run_pwm("nodir", 8'h06, 8'hA0, 8'h00, 16'h8, 16'h8, 16'h8, 40, 32, 0, 0);
    check("pin enable", {31'h0, compare_output_a_oe}, 32'h0);
    test_done();
  end
endmodule // tb_top
